/* global_priority_forward_pkg.sv */
// Constants for the global priority and forwarding register bank
package global_priority_forward_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] FACTORY_TEST_A_OFFSET = 8'h09;
   localparam logic [7:0] FACTORY_TEST_B_OFFSET = 8'h0A;
   localparam logic [7:0] HOST_CLOCK_SELECT_OFFSET = 8'h0B;
   localparam logic [7:0] PRIORITY_MAP_LOW_OFFSET = 8'h0C;
   localparam logic [7:0] PRIORITY_MAP_HIGH_OFFSET = 8'h0D;
   localparam logic [7:0] UNKNOWN_DEST_FORWARD_OFFSET = 8'h0E;
   localparam logic [7:0] FACTORY_TEST_A_RESET = 8'h24;
   localparam logic [7:0] FACTORY_TEST_B_RESET = 8'h35;
   localparam logic [7:0] PRIORITY_MAP_LOW_RESET = 8'h50;
   localparam logic [7:0] PRIORITY_MAP_HIGH_RESET = 8'hFA;
   // Clock select field position and read-only low pattern
   localparam int CLK_SEL_LSB = 6;
   localparam logic [1:0] CLK_SEL_RESET = 2'h2;
   localparam logic [5:0] CLK_SEL_RO_BITS = 6'h08;
   // Forwarding control bit positions
   localparam int FWD_ENABLE_BIT = 7;
   localparam int DRIVE_BIT = 6;
   localparam int RSVD_HI_BIT = 5;
   localparam int RSVD_RO_BIT = 4;
   localparam int RSVD_LO_BIT = 3;
   localparam logic FWD_ENABLE_RESET = 1'b0;
   localparam logic DRIVE_RESET = 1'b1;
   localparam logic RSVD_RW_RESET = 1'b0;
   localparam logic [2:0] PORT_MASK_RESET = 3'h7;
   typedef enum logic [1:0]
   {
      HOST_CLK_31M25 = 2'b00,
      HOST_CLK_62M5 = 2'b01,
      HOST_CLK_125M = 2'b10,
      HOST_CLK_RSVD = 2'b11
   } host_clk_e;
endpackage

/* global_priority_forward_regs.sv */
// Global control registers: host clock select, tag priority map, unknown-destination forwarding
`timescale 1ns/1ps
// Summary of operation
// - Clock select 00 runs host interface logic at 31.25 MHz, serial under 6 MHz.
// - Clock select 01 runs host interface logic at 62.5 MHz, serial 6 to 12.5 MHz.
// - Clock select in bits 7-6 value 10 gives 125 MHz; it is the reset default.
// - Each of eight tag values has a two-bit field giving the frame priority.
// - Low map register holds tags 0-3, resetting to 00, 00, 01, 01.
// - High map register holds tags 4-7, resetting to 10, 10, 11, 11.
// - Enable bit 7 sends unknown-destination frames only to masked ports; resets 0.
// - Mask bits 2-0 select ports 3, 2, 1; one includes, zero excludes.
// - Mask resets to 111 and acts only while the enable is set.
// - Drive bit selects 16 mA when set, 8 mA when clear; resets to 1.
// - Two factory-test registers are read-only, returning 0x24 and 0x35.
// - Unclassified or unclassifiable frames take the port default priority.
module global_priority_forward_regs
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register access from the management interface
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [global_priority_forward_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [global_priority_forward_pkg::DATA_W-1:0] reg_wdata,
   output logic [global_priority_forward_pkg::DATA_W-1:0] reg_rdata,
   // Frame classification request
   input wire logic cls_valid,
   input wire logic [2:0] cls_tag_pcp,
   input wire logic cls_classify_ok,
   input wire logic [1:0] cls_port_default,
   output logic cls_prio_valid,
   output logic [1:0] cls_prio,
   // Forwarding decision for unknown destination frames
   input wire logic [2:0] fwd_flood_ports,
   output logic [2:0] fwd_unknown_ports,
   // Static controls to clock generation and pads
   output logic [1:0] host_clk_sel,
   output logic pad_drive_16ma
);
   import global_priority_forward_pkg::*;

   // Every stored bit and every registered output lives in one struct
   typedef struct packed
   {
      // Host interface clock select
      logic [1:0] clk_sel;
      // Tag priority map, one two-bit field per tag value
      logic [1:0] prio_map_pcp_zero;
      logic [1:0] prio_map_pcp_one;
      logic [1:0] prio_map_pcp_two;
      logic [1:0] prio_map_pcp_three;
      logic [1:0] prio_map_pcp_four;
      logic [1:0] prio_map_pcp_five;
      logic [1:0] prio_map_pcp_six;
      logic [1:0] prio_map_pcp_seven;
      // Unknown-destination forwarding control
      logic fwd_enable;
      logic drive;
      logic rsvd_hi;
      logic rsvd_lo;
      logic [2:0] port_mask;
      // Registered read data and lookup results
      logic [7:0] rdata;
      logic prio_valid;
      logic [1:0] prio;
      logic [2:0] unknown_ports;
   } state_s;

   state_s state_reg;
   state_s state_next;
   // Register selects decoded once from the byte address
   logic hit_factory_a;
   logic hit_factory_b;
   logic hit_clk_sel;
   logic hit_map_low;
   logic hit_map_high;
   logic hit_fwd;
   // Read views of the two map registers and the forwarding register
   logic [7:0] map_low_view;
   logic [7:0] map_high_view;
   logic [7:0] fwd_view;
   logic [7:0] rd_mux;
   // Clock select code carried by the write data
   host_clk_e clk_sel_wr;
   // Tag lookup result before the port default is applied
   logic [1:0] mapped_prio;
   // Per-port choice between the mask and the normal flood set
   logic [2:0] port_pick;

   // Address decode shared by the read and write paths
   always_comb
   begin
      hit_factory_a = (reg_addr == FACTORY_TEST_A_OFFSET);
      hit_factory_b = (reg_addr == FACTORY_TEST_B_OFFSET);
      hit_clk_sel = (reg_addr == HOST_CLOCK_SELECT_OFFSET);
      hit_map_low = (reg_addr == PRIORITY_MAP_LOW_OFFSET);
      hit_map_high = (reg_addr == PRIORITY_MAP_HIGH_OFFSET);
      hit_fwd = (reg_addr == UNKNOWN_DEST_FORWARD_OFFSET);
   end

   // Fields are packed back in register order, tag 0 in the low bits
   always_comb
   begin
      map_low_view = {state_reg.prio_map_pcp_three, state_reg.prio_map_pcp_two,
         state_reg.prio_map_pcp_one, state_reg.prio_map_pcp_zero};
      map_high_view = {state_reg.prio_map_pcp_seven, state_reg.prio_map_pcp_six,
         state_reg.prio_map_pcp_five, state_reg.prio_map_pcp_four};
      // Bit 4 is read-only and always reads zero
      fwd_view = {state_reg.fwd_enable, state_reg.drive, state_reg.rsvd_hi, 1'b0,
         state_reg.rsvd_lo, state_reg.port_mask};
   end

   // Unmapped addresses read as zero
   always_comb
   begin
      rd_mux = 8'h00;
      if (hit_factory_a)
      begin
         rd_mux = FACTORY_TEST_A_RESET;
      end
      else if (hit_factory_b)
      begin
         rd_mux = FACTORY_TEST_B_RESET;
      end
      else if (hit_clk_sel)
      begin
         rd_mux = {state_reg.clk_sel, CLK_SEL_RO_BITS};
      end
      else if (hit_map_low)
      begin
         rd_mux = map_low_view;
      end
      else if (hit_map_high)
      begin
         rd_mux = map_high_view;
      end
      else if (hit_fwd)
      begin
         rd_mux = fwd_view;
      end
   end

   // Every code is kept as written so software reads back what it stored
   always_comb
   begin
      case (reg_wdata[CLK_SEL_LSB +: 2])
         HOST_CLK_31M25: clk_sel_wr = HOST_CLK_31M25;
         HOST_CLK_62M5: clk_sel_wr = HOST_CLK_62M5;
         HOST_CLK_125M: clk_sel_wr = HOST_CLK_125M;
         // Unassigned code, left to the clock generator to interpret
         HOST_CLK_RSVD: clk_sel_wr = HOST_CLK_RSVD;
         default: clk_sel_wr = HOST_CLK_125M;
      endcase
   end

   always_comb
   begin
      case (cls_tag_pcp)
         3'h0: mapped_prio = state_reg.prio_map_pcp_zero;
         3'h1: mapped_prio = state_reg.prio_map_pcp_one;
         3'h2: mapped_prio = state_reg.prio_map_pcp_two;
         3'h3: mapped_prio = state_reg.prio_map_pcp_three;
         3'h4: mapped_prio = state_reg.prio_map_pcp_four;
         3'h5: mapped_prio = state_reg.prio_map_pcp_five;
         3'h6: mapped_prio = state_reg.prio_map_pcp_six;
         3'h7: mapped_prio = state_reg.prio_map_pcp_seven;
         default: mapped_prio = state_reg.prio_map_pcp_zero;
      endcase
   end

   // normal flood
   // Mask bit 2 steers port 3 and bit 0 port 1, the same order as the flood set
   always_comb
   begin
      for (int p = 0; p < 3; p++)
      begin
         port_pick[p] = state_reg.fwd_enable ? state_reg.port_mask[p] : fwd_flood_ports[p];
      end
   end

   always_comb
   begin
      state_next = state_reg;
      // Read data holds until the next read so a slow serial engine can shift it out
      if (reg_rd)
      begin
         state_next.rdata = rd_mux;
      end

      // Clock select write
      if (reg_wr && hit_clk_sel)
      begin
         state_next.clk_sel = clk_sel_wr;
      end

      if (reg_wr && hit_map_low)
      begin
         state_next.prio_map_pcp_zero = reg_wdata[1:0];
         state_next.prio_map_pcp_one = reg_wdata[3:2];
         state_next.prio_map_pcp_two = reg_wdata[5:4];
         state_next.prio_map_pcp_three = reg_wdata[7:6];
      end

      if (reg_wr && hit_map_high)
      begin
         state_next.prio_map_pcp_four = reg_wdata[1:0];
         state_next.prio_map_pcp_five = reg_wdata[3:2];
         state_next.prio_map_pcp_six = reg_wdata[5:4];
         state_next.prio_map_pcp_seven = reg_wdata[7:6];
      end

      if (reg_wr && hit_fwd)
      begin
         state_next.fwd_enable = reg_wdata[FWD_ENABLE_BIT];
         state_next.drive = reg_wdata[DRIVE_BIT];
         // Reserved bits 5 and 3 stored; bit 4 is not
         state_next.rsvd_hi = reg_wdata[RSVD_HI_BIT];
         state_next.rsvd_lo = reg_wdata[RSVD_LO_BIT];
         state_next.port_mask = reg_wdata[2:0];
      end

      // test read-only
      // Writes to the factory-test addresses have no storage to land in
      state_next.prio_valid = cls_valid;
      if (cls_valid)
      begin
         if (!cls_classify_ok)
         begin
            state_next.prio = cls_port_default;
         end
         else
         begin
            state_next.prio = mapped_prio;
         end
      end

      state_next.unknown_ports = port_pick;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         state_reg.clk_sel <= CLK_SEL_RESET;
         state_reg.prio_map_pcp_zero <= PRIORITY_MAP_LOW_RESET[1:0];
         state_reg.prio_map_pcp_one <= PRIORITY_MAP_LOW_RESET[3:2];
         state_reg.prio_map_pcp_two <= PRIORITY_MAP_LOW_RESET[5:4];
         state_reg.prio_map_pcp_three <= PRIORITY_MAP_LOW_RESET[7:6];
         state_reg.prio_map_pcp_four <= PRIORITY_MAP_HIGH_RESET[1:0];
         state_reg.prio_map_pcp_five <= PRIORITY_MAP_HIGH_RESET[3:2];
         state_reg.prio_map_pcp_six <= PRIORITY_MAP_HIGH_RESET[5:4];
         state_reg.prio_map_pcp_seven <= PRIORITY_MAP_HIGH_RESET[7:6];
         state_reg.fwd_enable <= FWD_ENABLE_RESET;
         state_reg.drive <= DRIVE_RESET;
         state_reg.rsvd_hi <= RSVD_RW_RESET;
         state_reg.rsvd_lo <= RSVD_RW_RESET;
         state_reg.port_mask <= PORT_MASK_RESET;
         // Read data and lookup outputs clear too, so nothing downstream acts on a stale lookup
         state_reg.rdata <= 8'h00;
         state_reg.prio_valid <= 1'b0;
         state_reg.prio <= 2'h0;
         state_reg.unknown_ports <= 3'h0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Outputs come straight from the state register
   assign reg_rdata = state_reg.rdata;
   assign cls_prio_valid = state_reg.prio_valid;
   assign cls_prio = state_reg.prio;
   assign fwd_unknown_ports = state_reg.unknown_ports;
   assign host_clk_sel = state_reg.clk_sel;
   assign pad_drive_16ma = state_reg.drive;

endmodule // global_priority_forward_regs

/* global_priority_forward_regs_assertions.sv */
// Port-level assertions for the global priority and forwarding registers
`timescale 1ns/1ps
module global_priority_forward_regs_assertions
(
   // Watched ports of the register bank
   input wire logic clk,
   input wire logic reset_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic cls_valid,
   input wire logic cls_classify_ok,
   input wire logic [1:0] cls_port_default,
   input wire logic cls_prio_valid,
   input wire logic [1:0] cls_prio,
   input wire logic [2:0] fwd_flood_ports,
   input wire logic [2:0] fwd_unknown_ports,
   input wire logic [1:0] host_clk_sel,
   input wire logic pad_drive_16ma
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   property p_sel; reg_wr && reg_addr == 8'h0B |=> {host_clk_sel, 6'h00} == ($past(reg_wdata) & 8'hC0); endproperty
   a_sel: assert property (p_sel) else $error("clock select not as written");
   property p_rst; $rose(reset_n) |-> host_clk_sel == 2'b10 && pad_drive_16ma; endproperty
   a_rst: assert property (p_rst) else $error("wrong value after reset");
   property p_drv; reg_wr && reg_addr == 8'h0E |=> pad_drive_16ma == |($past(reg_wdata) & 8'h40); endproperty
   a_drv: assert property (p_drv) else $error("drive strength not as written");
   property p_on; reg_wr && reg_addr == 8'h0E && reg_wdata[7] |=> ##1 {5'h00, fwd_unknown_ports} == ($past(reg_wdata, 2) & 8'h07); endproperty
   a_on: assert property (p_on) else $error("unknown ports differ from mask");
   property p_off; reg_wr && reg_addr == 8'h0E && !reg_wdata[7] ##1 1 |=> fwd_unknown_ports == $past(fwd_flood_ports); endproperty
   a_off: assert property (p_off) else $error("mask used while disabled");
   property p_val; cls_valid |=> cls_prio_valid; endproperty
   a_val: assert property (p_val) else $error("no classification result");
   property p_def; cls_valid && !cls_classify_ok |=> cls_prio == $past(cls_port_default); endproperty
   a_def: assert property (p_def) else $error("port default not used");
   property p_fix; reg_rd && (reg_addr == 8'h09 || reg_addr == 8'h0A) |=> reg_rdata == ($past(reg_addr) == 8'h09 ? 8'h24 : 8'h35); endproperty
   a_fix: assert property (p_fix) else $error("factory test value wrong");
endmodule // global_priority_forward_regs_assertions
bind global_priority_forward_regs global_priority_forward_regs_assertions chk_u (.clk, .reset_n, .reg_wr, .reg_rd,
   .reg_addr, .reg_wdata, .reg_rdata, .cls_valid, .cls_classify_ok, .cls_port_default, .cls_prio_valid, .cls_prio,
   .fwd_flood_ports, .fwd_unknown_ports, .host_clk_sel, .pad_drive_16ma);

/* testbench.sv */
// Self-checking bench for the global priority and forwarding registers
`timescale 1ns/1ps
module testbench;
   logic clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, cls_valid = 0, cls_classify_ok = 0, cls_prio_valid, pad_drive_16ma;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
   logic [2:0] cls_tag_pcp = 0, fwd_flood_ports = 3'h5, fwd_unknown_ports;
   logic [1:0] cls_port_default = 0, cls_prio, host_clk_sel;
   logic [15:0] map = 16'hFA50;
   logic [7:0] rst [7] = '{8'h24, 8'h35, 8'h88, 8'h50, 8'hFA, 8'h47, 8'h00};
   int fail_count = 0, cmp_count = 0;
   initial forever #25 clk = ~clk;
   global_priority_forward_regs dut_u (.clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .cls_valid,
      .cls_tag_pcp, .cls_classify_ok, .cls_port_default, .cls_prio_valid, .cls_prio, .fwd_flood_ports,
      .fwd_unknown_ports, .host_clk_sel, .pad_drive_16ma);
   task automatic chk(string n, logic [7:0] s, logic [7:0] e);
      cmp_count++;
      if (s !== e)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // Write when w is set, otherwise read and compare against d
   task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 0;
      reg_rd <= 0;
      @(negedge clk);
      if (!w)
         chk("reg_rdata", reg_rdata, d);
   endtask
   // Port default is made to differ from the mapped value unless it is the expected one
   task automatic cls(logic [2:0] t, logic ok, logic [1:0] e);
      @(posedge clk);
      cls_valid <= 1;
      cls_tag_pcp <= t;
      cls_classify_ok <= ok;
      cls_port_default <= ok ? ~e : e;
      @(posedge clk);
      cls_valid <= 0;
      @(negedge clk);
      chk("cls_prio", {5'h00, cls_prio_valid, cls_prio}, {5'h01, e});
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      reset_n <= 1;
      for (int i = 0; i < 7; i++)
         acc(0, 8'(9 + i), rst[i]);
      acc(1, 8'h09, 8'hFF);
      acc(0, 8'h09, 8'h24);
      for (int s = 0; s < 3; s++)
      begin
         acc(1, 8'h0B, 8'(s * 64 + 63));
         chk("host_clk_sel", 8'(host_clk_sel), 8'(s));
         acc(0, 8'h0B, 8'(s * 64 + 8));
      end
      acc(1, 8'h0B, 8'h00);
      chk("host_clk_sel", 8'(host_clk_sel), 8'h00);
      $display("test registers done");
      for (int k = 0; k < 16; k++)
      begin
         if (k == 8)
         begin
            acc(1, 8'h0C, 8'h1B);
            acc(1, 8'h0D, 8'hE4);
            map = 16'hE41B;
         end
         cls(3'(k), 1, 2'(map >> (2 * (k % 8))));
      end
      cls(3'h7, 0, 2'h2);
      $display("test classification done");
      chk("fwd_unknown_ports", 8'(fwd_unknown_ports), 8'h05);
      acc(1, 8'h0E, 8'h82);
      @(negedge clk);
      chk("fwd_unknown_ports", 8'(fwd_unknown_ports), 8'h02);
      acc(1, 8'h0E, 8'h07);
      chk("pad_drive_16ma", 8'(pad_drive_16ma), 8'h00);
      @(negedge clk);
      chk("fwd_unknown_ports", 8'(fwd_unknown_ports), 8'h05);
      acc(1, 8'h0E, 8'hD7);
      chk("pad_drive_16ma", 8'(pad_drive_16ma), 8'h01);
      acc(0, 8'h0E, 8'hC7);
      $display("test forwarding done");
      final_report();
   end
endmodule // testbench
